// file: rtl/sion_pkg.sv
// Shared constants and state types for the satellite I/O node and its controller.
// Assumes one 100 MHz core clock on both ends and a single serial line in each direction.
package sion_pkg;

  localparam int CLK_FREQ_HZ     = 100_000_000;
  localparam int BIT_CYCLES      = 4;
  localparam int BAUD_BPS        = CLK_FREQ_HZ / BIT_CYCLES;

  localparam int ADDR_W          = 6;
  localparam int CMD_W           = 4;
  localparam int WORD_W          = 16;
  localparam int REQ_W           = ADDR_W + CMD_W + WORD_W;
  localparam int CP_PAY          = REQ_W + 1;
  localparam int RP_PAY          = WORD_W + 1;
  localparam int CP_FRAME        = CP_PAY + 2;
  localparam int RP_FRAME        = RP_PAY + 2;

  localparam logic [1:0] CYC_LAST        = 2'(BIT_CYCLES - 1);
  localparam logic [1:0] START_MID       = 2'h1;
  localparam logic [4:0] CP_LAST_IDX     = 5'(CP_PAY - 1);
  localparam logic [4:0] RP_LAST_IDX     = 5'(RP_PAY - 1);
  localparam logic [4:0] NODE_TX_LAST    = 5'(RP_FRAME - 1);
  localparam logic [4:0] CTRL_TX_LAST    = 5'(CP_FRAME - 1);

  localparam logic [CMD_W-1:0]  CMD_BASIC_A   = 4'h0;
  localparam logic [CMD_W-1:0]  CMD_BASIC_B   = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_MIN      = 6'h01;
  localparam logic [ADDR_W-1:0] ADDR_MAX      = 6'h3F;
  localparam logic [WORD_W-1:0] WORD_CLEARED  = 16'hFFFF;
  localparam logic [WORD_W-1:0] WORD_EXTENDED = 16'h0000;
  localparam logic [WORD_W-1:0] OUT_RESET     = 16'h0000;

  localparam int RESP_TIMEOUT_BITS   = 40;
  localparam int RESP_TIMEOUT_CYCLES = RESP_TIMEOUT_BITS * BIT_CYCLES;
  localparam logic [7:0] TMO_LAST    = 8'(RESP_TIMEOUT_CYCLES - 1);

  localparam int REQ_FIFO_DEPTH = 16;

  typedef enum logic [2:0] {
    N_IDLE  = 3'b000,
    N_START = 3'b001,
    N_BITS  = 3'b010,
    N_STOP  = 3'b011,
    N_TX    = 3'b100
  } sion_node_state_type;

  typedef enum logic [2:0] {
    C_IDLE  = 3'b000,
    C_SEND  = 3'b001,
    C_WAIT  = 3'b010,
    C_START = 3'b011,
    C_BITS  = 3'b100,
    C_STOP  = 3'b101
  } sion_ctrl_state_type;

endpackage

// file: rtl/sion_link_if.sv
// Serial field link between the controller and one satellite node.
// Assumes the node drives its line only while its transmit enable is high; the line idles high.
interface sion_link_if;
  logic cmdLine;   // Controller to node, idle high.
  logic nodeTxd;   // Node transmit data.
  logic nodeTxe;   // Node transmit enable.
  logic respLine;  // Resolved node-to-controller line.

  assign respLine = nodeTxe ? nodeTxd : 1'b1;

  modport node (input cmdLine, output nodeTxd, output nodeTxe);
  modport ctrl (output cmdLine, input respLine);
endinterface

// file: rtl/sion_node.sv
// Satellite I/O node: receives command packets, answers with response packets, drives 16 outputs.
// Assumes all pins and the link are asynchronous to core_clk and the controller sends one packet at a time.
// Function
// RL1 - Clock runs at four times baud rate.
// RL2 - Clock output runs continuously, even in reset.
// RL3 - Supported clock to baud pairings fixed.
// RL4 - Reset low pulses under one clock ignored.
// RL5 - System holds reset low ten clocks.
// RL6 - Station address from six pins, MSB highest.
// RL7 - Addresses unique; address zero never scanned.
// RL8 - Matching command packet triggers immediate response.
// RL9 - Transmit enable high exactly while sending.
// RL10 - Transmit pins hold in reset, low after.
// RL11 - Receive input ignored while transmit enabled.
// RL12 - Inputs reported as one word, bit order.
// RL13 - Other command codes report no input states.
// RL14 - Clear high at sampling reports all ones.
// RL15 - Good matching packet loads held output word.
// RL16 - Output word bit n drives pin n.
// RL17 - Output pins hold in reset, low after.
// RL18 - Clear forces outputs low, discards data.
// RL19 - Four clock cycles per bit, both directions.
module sion_node
  import sion_pkg::*;
(
  input  wire logic                core_clk,         // Driving clock.
  input  wire logic                srst,             // Synchronous reset, active high.
  input  wire logic                hwRstN,           // Hardware reset pin, active low.
  input  wire logic [ADDR_W-1:0]   stationAddrPins,  // Station address straps.
  input  wire logic [WORD_W-1:0]   inputPins,        // Digital inputs.
  input  wire logic                forceOutputsLow,  // Clear input, active high.
  output logic      [WORD_W-1:0]   outputPins,       // Digital outputs.
  output logic                     clockMonitorOut,  // Clock out for cascaded parts.
  sion_link_if.node                link              // Serial link.
);

  logic                rstS1_r;
  logic                rstS2_r;
  logic                rstS3_r;
  logic                coreRst;
  logic                inReset_r = 1'b0;
  logic                cmdS1_r;
  logic                cmdS2_r;
  logic [ADDR_W-1:0]   addrS1_r;
  logic [ADDR_W-1:0]   stationAddress_r;
  logic [WORD_W-1:0]   inS1_r;
  logic [WORD_W-1:0]   inS2_r;
  logic                clrS1_r;
  logic                clrS2_r;
  logic                rxIn;
  sion_node_state_type state_r;
  logic [1:0]          cyc_r;
  logic [4:0]          idx_r;
  logic [CP_PAY-1:0]   rxShift_r;
  logic [RP_FRAME-2:0] txShift_r;
  logic                txd_r = 1'b0;
  logic                txe_r = 1'b0;
  logic [WORD_W-1:0]   outWord_r = OUT_RESET;
  logic                frameOk;
  logic                bitEnd;
  logic [WORD_W-1:0]   respWord;
  logic [RP_FRAME-1:0] respFrame;

  // The clock leaves ungated so cascaded parts keep running through reset.
  assign clockMonitorOut = core_clk;  // RL2

  assign outputPins   = outWord_r;  // RL16
  assign link.nodeTxd = txd_r;
  assign link.nodeTxe = txe_r;

  // A low level counts only once two successive edges have seen it, so a shorter dip is dropped.
  always_ff @(posedge core_clk) begin
    rstS1_r <= hwRstN;
    rstS2_r <= rstS1_r;
    rstS3_r <= rstS2_r;
  end

  assign coreRst = srst | (!rstS2_r & !rstS3_r);  // RL4

  always_ff @(posedge core_clk) begin
    inReset_r <= coreRst;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmdS1_r <= 1'b1;
      cmdS2_r <= 1'b1;
      addrS1_r <= '0;
      stationAddress_r <= '0;
      inS1_r <= '0;
      inS2_r <= '0;
      clrS1_r <= 1'b0;
      clrS2_r <= 1'b0;
    end else begin
      cmdS1_r <= link.cmdLine;
      cmdS2_r <= cmdS1_r;
      addrS1_r <= stationAddrPins;
      stationAddress_r <= addrS1_r;  // RL6
      inS1_r <= inputPins;
      inS2_r <= inS1_r;
      clrS1_r <= forceOutputsLow;
      clrS2_r <= clrS1_r;
    end
  end

  // Our own echo on a half-duplex pair would otherwise look like a fresh start bit.
  assign rxIn = txe_r ? 1'b1 : cmdS2_r;  // RL11

  assign bitEnd = (cyc_r == CYC_LAST);  // RL1 RL3 RL19

  // A packet counts only with the right address, a high stop bit and even parity.
  assign frameOk = (state_r == N_STOP) && bitEnd && rxIn &&
                   (rxShift_r[ADDR_W-1:0] == stationAddress_r) && !(^rxShift_r);  // RL8

  always_comb begin
    if ((rxShift_r[ADDR_W+CMD_W-1:ADDR_W] == CMD_BASIC_A) ||
        (rxShift_r[ADDR_W+CMD_W-1:ADDR_W] == CMD_BASIC_B)) begin
      respWord = clrS2_r ? WORD_CLEARED : inS2_r;  // RL12 RL14
    end else begin
      respWord = WORD_EXTENDED;  // RL13
    end
  end

  assign respFrame = {1'b1, ^respWord, respWord, 1'b0};

  always_ff @(posedge core_clk) begin
    if (coreRst) begin
      state_r <= N_IDLE;
      cyc_r <= '0;
      idx_r <= '0;
      rxShift_r <= '0;
      txShift_r <= '0;
    end else begin
      case (state_r)
        N_IDLE: begin
          cyc_r <= '0;
          idx_r <= '0;
          if (!rxIn) begin
            state_r <= N_START;
          end
        end
        N_START: begin
          cyc_r <= 2'(cyc_r + 2'h1);
          if (cyc_r == START_MID) begin
            cyc_r <= '0;
            state_r <= rxIn ? N_IDLE : N_BITS;
          end
        end
        N_BITS: begin
          cyc_r <= 2'(cyc_r + 2'h1);  // RL19
          if (bitEnd) begin
            rxShift_r <= {rxIn, rxShift_r[CP_PAY-1:1]};
            idx_r <= 5'(idx_r + 5'h01);
            if (idx_r == CP_LAST_IDX) begin
              idx_r <= '0;
              state_r <= N_STOP;
            end
          end
        end
        N_STOP: begin
          cyc_r <= 2'(cyc_r + 2'h1);
          if (bitEnd) begin
            idx_r <= '0;
            if (frameOk) begin
              txShift_r <= respFrame[RP_FRAME-1:1];  // RL8
              state_r <= N_TX;
            end else begin
              state_r <= N_IDLE;
            end
          end
        end
        N_TX: begin
          cyc_r <= 2'(cyc_r + 2'h1);  // RL19
          if (bitEnd) begin
            txShift_r <= {1'b0, txShift_r[RP_FRAME-2:1]};
            idx_r <= 5'(idx_r + 5'h01);
            if (idx_r == NODE_TX_LAST) begin
              state_r <= N_IDLE;
            end
          end
        end
        default: begin
          state_r <= N_IDLE;
        end
      endcase
    end
  end

  // Transmit pins keep their level through reset and drop on the first edge after it ends.
  always_ff @(posedge core_clk) begin
    if (coreRst) begin
      txe_r <= txe_r;  // RL10
      txd_r <= txd_r;
    end else if (inReset_r) begin
      txe_r <= 1'b0;  // RL10
      txd_r <= 1'b0;
    end else if (frameOk) begin
      txe_r <= 1'b1;  // RL9
      txd_r <= respFrame[0];
    end else if ((state_r == N_TX) && bitEnd) begin
      if (idx_r == NODE_TX_LAST) begin
        txe_r <= 1'b0;  // RL9
        txd_r <= 1'b0;
      end else begin
        txd_r <= txShift_r[0];  // RL9
      end
    end
  end

  // Clear wins over an update arriving in the same cycle, so nothing stale survives it.
  always_ff @(posedge core_clk) begin
    if (coreRst) begin
      outWord_r <= outWord_r;  // RL17
    end else if (inReset_r) begin
      outWord_r <= OUT_RESET;  // RL17
    end else if (clrS2_r) begin
      outWord_r <= OUT_RESET;  // RL18
    end else if (frameOk) begin
      outWord_r <= rxShift_r[REQ_W-1:ADDR_W+CMD_W];  // RL15 RL16
    end
  end

endmodule

// file: rtl/sion_ctrl.sv
// Central controller end: request FIFO, command packet sender and response receiver.
// Assumes one node answers per request and the response line idles high when no node drives it.
module sion_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,  // Clock.
  input  wire logic             srst,      // Synchronous reset, active high.
  input  wire logic             inValid,   // Write request.
  output logic                  inReady,   // Room for a word.
  input  wire logic [WIDTH-1:0] inData,    // Write data.
  output logic                  outValid,  // Word available.
  input  wire logic             outReady,  // Read acknowledge.
  output logic      [WIDTH-1:0] outData    // Oldest word.
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      cnt_r;
  logic [AW:0]      cnt_nxt;
  logic             inReady_r;
  logic             push;
  logic             pop;

  assign inReady  = inReady_r;
  assign outValid = (cnt_r != '0);
  assign outData  = mem[rdPtr_r];
  assign push     = inValid & inReady_r;
  assign pop      = outValid & outReady;

  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = (AW+1)'(cnt_r + 1'b1);
    end else if (pop && !push) begin
      cnt_nxt = (AW+1)'(cnt_r - 1'b1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      cnt_r <= '0;
      inReady_r <= 1'b0;
    end else begin
      if (push) begin
        wrPtr_r <= AW'(wrPtr_r + 1'b1);
      end
      if (pop) begin
        rdPtr_r <= AW'(rdPtr_r + 1'b1);
      end
      cnt_r <= cnt_nxt;
      inReady_r <= (cnt_nxt != (AW+1)'(DEPTH));
    end
  end
endmodule

module sion_ctrl
  import sion_pkg::*;
(
  input  wire logic               core_clk,    // Core clock.
  input  wire logic               srst,        // Synchronous reset, active high.
  input  wire logic               reqValid,    // Request offered.
  output logic                    reqReady,    // Request FIFO has room.
  input  wire logic [ADDR_W-1:0]  reqAddr,     // Target station address.
  input  wire logic [CMD_W-1:0]   reqCmd,      // Command code.
  input  wire logic [WORD_W-1:0]  reqData,     // Output word for the node.
  output logic                    rspValid,    // Response received, one cycle.
  output logic      [WORD_W-1:0]  rspWord,     // Response input word.
  output logic                    rspOk,       // Parity and stop bit good.
  output logic                    rspTimeout,  // No answer, one cycle.
  sion_link_if.ctrl               link         // Serial link.
);

  logic                 respS1_r;
  logic                 respS2_r;
  logic                 fifoValid;
  logic [REQ_W-1:0]     fifoData;
  logic [CP_PAY-1:0]    pay;
  sion_ctrl_state_type  state_r;
  logic [1:0]           cyc_r;
  logic [4:0]           idx_r;
  logic [7:0]           tmo_r;
  logic [CP_FRAME-1:0]  txShift_r;
  logic [RP_PAY-1:0]    rxShift_r;
  logic                 cmdLine_r;
  logic                 rspValid_r;
  logic [WORD_W-1:0]    rspWord_r;
  logic                 rspOk_r;
  logic                 rspTimeout_r;
  logic                 bitEnd;

  sion_fifo #(.WIDTH(REQ_W), .DEPTH(REQ_FIFO_DEPTH)) u_reqFifo (
    .core_clk (core_clk),
    .srst     (srst),
    .inValid  (reqValid),
    .inReady  (reqReady),
    .inData   ({reqData, reqCmd, reqAddr}),
    .outValid (fifoValid),
    .outReady (state_r == C_IDLE),
    .outData  (fifoData)
  );

  assign link.cmdLine = cmdLine_r;
  assign rspValid     = rspValid_r;
  assign rspWord      = rspWord_r;
  assign rspOk        = rspOk_r;
  assign rspTimeout   = rspTimeout_r;
  assign pay          = {^fifoData, fifoData};
  assign bitEnd       = (cyc_r == CYC_LAST);  // RL1 RL3 RL19

  always_ff @(posedge core_clk) begin
    if (srst) begin
      respS1_r <= 1'b1;
      respS2_r <= 1'b1;
    end else begin
      respS1_r <= link.respLine;
      respS2_r <= respS1_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r <= C_IDLE;
      cyc_r <= '0;
      idx_r <= '0;
      tmo_r <= '0;
      txShift_r <= '1;
      rxShift_r <= '0;
      cmdLine_r <= 1'b1;
      rspValid_r <= 1'b0;
      rspWord_r <= '0;
      rspOk_r <= 1'b0;
      rspTimeout_r <= 1'b0;
    end else begin
      rspValid_r <= 1'b0;
      rspTimeout_r <= 1'b0;
      case (state_r)
        C_IDLE: begin
          cyc_r <= '0;
          idx_r <= '0;
          cmdLine_r <= 1'b1;
          if (fifoValid) begin
            txShift_r <= {1'b1, 1'b1, pay};
            cmdLine_r <= 1'b0;
            state_r <= C_SEND;
          end
        end
        C_SEND: begin
          cyc_r <= 2'(cyc_r + 2'h1);
          if (bitEnd) begin
            idx_r <= 5'(idx_r + 5'h01);
            cmdLine_r <= txShift_r[0];
            txShift_r <= {1'b1, txShift_r[CP_FRAME-1:1]};
            if (idx_r == CTRL_TX_LAST) begin
              cmdLine_r <= 1'b1;
              tmo_r <= '0;
              state_r <= C_WAIT;
            end
          end
        end
        C_WAIT: begin
          cyc_r <= '0;
          idx_r <= '0;
          tmo_r <= 8'(tmo_r + 8'h01);
          if (!respS2_r) begin
            state_r <= C_START;
          end else if (tmo_r == TMO_LAST) begin
            rspTimeout_r <= 1'b1;
            state_r <= C_IDLE;
          end
        end
        C_START: begin
          cyc_r <= 2'(cyc_r + 2'h1);
          if (cyc_r == START_MID) begin
            cyc_r <= '0;
            state_r <= respS2_r ? C_WAIT : C_BITS;
          end
        end
        C_BITS: begin
          cyc_r <= 2'(cyc_r + 2'h1);
          if (bitEnd) begin
            rxShift_r <= {respS2_r, rxShift_r[RP_PAY-1:1]};
            idx_r <= 5'(idx_r + 5'h01);
            if (idx_r == RP_LAST_IDX) begin
              state_r <= C_STOP;
            end
          end
        end
        C_STOP: begin
          cyc_r <= 2'(cyc_r + 2'h1);
          if (bitEnd) begin
            rspValid_r <= 1'b1;
            rspWord_r <= rxShift_r[WORD_W-1:0];
            rspOk_r <= respS2_r & !(^rxShift_r);
            state_r <= C_IDLE;
          end
        end
        default: begin
          state_r <= C_IDLE;
        end
      endcase
    end
  end

endmodule

// file: testbench/sion_link_asserts.sv
// Concurrent checks on the serial link between the controller and one satellite node.
// Assumes the bench feeds it the link interface signals and the shared core clock and reset.
module sion_link_asserts (
  input wire logic core_clk,  // Core clock.
  input wire logic srst,      // Synchronous reset, active high.
  input wire logic cmdLine,   // Controller to node.
  input wire logic nodeTxd,   // Node transmit data.
  input wire logic nodeTxe,   // Node transmit enable.
  input wire logic respLine   // Resolved return line.
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] txeCnt_r;
  logic       parity_r;

  // Counts the enable-high cycles of the current response.
  always_ff @(posedge core_clk) begin
    if (srst || !nodeTxe) begin
      txeCnt_r <= 8'h00;
    end else begin
      txeCnt_r <= txeCnt_r + 8'h01;
    end
  end

  // Folds the payload bits, sampled mid-bit, so the stop edge can judge even parity.
  always_ff @(posedge core_clk) begin
    if (srst || !nodeTxe) begin
      parity_r <= 1'b0;
    end else if (txeCnt_r[1:0] == 2'h2 && txeCnt_r >= 8'h04 && txeCnt_r < 8'h48) begin
      parity_r <= parity_r ^ nodeTxd;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  resp_length_a: assert property ($fell(nodeTxe) && !$past(srst, 2) |-> txeCnt_r == 8'h4C)
    else $error("response enable length wrong");
  resp_bound_a: assert property (txeCnt_r <= 8'h4C)
    else $error("response enable too long");
  start_bit_a: assert property ($rose(nodeTxe) |-> !nodeTxd [*4])
    else $error("start bit missing");
  stop_bit_a: assert property ($fell(nodeTxe) && !$past(srst, 2) |-> $past(nodeTxd))
    else $error("stop bit missing");
  bit_timing_a: assert property (nodeTxe && $past(nodeTxe) && $changed(nodeTxd) |-> txeCnt_r[1:0] == 2'h0)
    else $error("transmit bit edge off grid");
  resp_parity_a: assert property ($fell(nodeTxe) && !$past(srst, 2) |-> !parity_r)
    else $error("response parity odd");
  tx_idle_a: assert property (!nodeTxe && !$past(srst) |-> !nodeTxd)
    else $error("transmit data high while idle");
  reset_clear_a: assert property ($fell(srst) |-> $stable(nodeTxe) && $stable(nodeTxd) ##1 !nodeTxe && !nodeTxd)
    else $error("transmit pins wrong around reset");
  half_duplex_a: assert property (nodeTxe |-> cmdLine)
    else $error("command sent during response");
  cmd_start_a: assert property ($fell(cmdLine) |-> !cmdLine [*3])
    else $error("command start bit short");
  resp_release_a: assert property (!nodeTxe |-> respLine)
    else $error("return line not released while idle");
  resp_drive_a: assert property (nodeTxe |-> respLine == nodeTxd)
    else $error("return line not following node data");

  cover property ($rose(nodeTxe));
  cover property ($fell(nodeTxe) && txeCnt_r == 8'h4C);
  cover property ($fell(cmdLine));
endmodule

// file: testbench/satellite_io_node_test.sv
// Self-checking bench: controller and satellite node joined by the link interface.
// Assumes a 100 MHz core clock; responses are gathered by a monitor and checked in order.
module satellite_io_node_test
  import sion_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic              core_clk;
  logic              srst;
  logic              hwRstN;
  logic              forceOutputsLow;
  logic              reqValid;
  logic              reqReady;
  logic              rspValid;
  logic              rspOk;
  logic              rspTimeout;
  logic              clockMonitorOut;
  logic              sawFull;
  logic [ADDR_W-1:0] stationAddrPins;
  logic [ADDR_W-1:0] reqAddr;
  logic [CMD_W-1:0]  reqCmd;
  logic [WORD_W-1:0] reqData;
  logic [WORD_W-1:0] rspWord;
  logic [WORD_W-1:0] inputPins;
  logic [WORD_W-1:0] outputPins;
  logic [17:0]       rspQ[$];
  int                mismatches = 0;
  int                checks = 0;

  sion_link_if link ();
  sion_node i_sion_node (.core_clk, .srst, .hwRstN, .stationAddrPins, .inputPins, .forceOutputsLow,
    .outputPins, .clockMonitorOut, .link(link.node));
  sion_ctrl i_sion_ctrl (.core_clk, .srst, .reqValid, .reqReady, .reqAddr, .reqCmd, .reqData,
    .rspValid, .rspWord, .rspOk, .rspTimeout, .link(link.ctrl));
  sion_link_asserts i_sion_link_asserts (.core_clk, .srst, .cmdLine(link.cmdLine),
    .nodeTxd(link.nodeTxd), .nodeTxe(link.nodeTxe), .respLine(link.respLine));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Pulses last one cycle, so they are caught here even while a task waits elsewhere.
  always @(posedge core_clk) begin
    if (rspValid === 1'b1 || rspTimeout === 1'b1) begin
      rspQ.push_back({rspTimeout, rspOk, rspWord});
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (mismatches == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic tick(input int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Leaves reqValid high so a burst can follow without a gap.
  task automatic push(input logic [ADDR_W-1:0] a, input logic [CMD_W-1:0] c, input logic [WORD_W-1:0] d);
    int n = 0;
    reqValid = 1'b1;
    reqAddr = a;
    reqCmd = c;
    reqData = d;
    while (reqReady !== 1'b1) begin
      sawFull = 1'b1;
      tick();
      n++;
      if (n > 2000) begin
        mismatches++;
        report_and_stop();
      end
    end
    tick();
  endtask

  task automatic expect_rsp(input logic hit, input logic [WORD_W-1:0] w);
    int n = 0;
    logic [17:0] r;
    while (rspQ.size() == 0) begin
      tick();
      n++;
      if (n > 600) begin
        mismatches++;
        report_and_stop();
      end
    end
    r = rspQ.pop_front();
    check(r[17], !hit);
    if (hit) begin
      check(r[16:0], {1'b1, w});
    end
  endtask

  function automatic logic [WORD_W-1:0] exp_word(input logic [CMD_W-1:0] c, input logic clr,
                                                  input logic [WORD_W-1:0] ins);
    if (c != CMD_BASIC_A && c != CMD_BASIC_B) begin
      return WORD_EXTENDED;
    end
    return clr ? WORD_CLEARED : ins;
  endfunction

  task automatic xact(input logic [ADDR_W-1:0] a, input logic [CMD_W-1:0] c, input logic [WORD_W-1:0] d,
                      input logic hit);
    logic [WORD_W-1:0] prevOut;
    prevOut = outputPins;
    push(a, c, d);
    reqValid = 1'b0;
    expect_rsp(hit, exp_word(c, forceOutputsLow, inputPins));
    check(outputPins, forceOutputsLow ? OUT_RESET : (hit ? d : prevOut));
  endtask

  initial begin
    logic [ADDR_W-1:0] sa;
    logic [WORD_W-1:0] held;
    int                i;
    srst = 1'b1;
    hwRstN = 1'b0;
    forceOutputsLow = 1'b0;
    reqValid = 1'b0;
    reqAddr = 6'h00;
    reqCmd = 4'h0;
    reqData = 16'h0000;
    stationAddrPins = 6'h01;
    inputPins = 16'h0000;
    sawFull = 1'b0;
    i = $urandom(33);
    tick(8);
    srst = 1'b0;
    tick(4);
    hwRstN = 1'b1;
    tick(4);
    for (i = 0; i < 16; i++) begin
      sa = (i == 0) ? ADDR_MIN : (i == 15) ? ADDR_MAX : ADDR_W'(1 + $urandom % 63);
      stationAddrPins = sa;
      inputPins = WORD_W'($urandom);
      tick(4);
      xact(sa, CMD_W'(i), WORD_W'($urandom), 1'b1);
      if (i % 4 == 3) begin
        xact((sa == ADDR_MAX) ? ADDR_MIN : sa + 6'h01, CMD_W'(i), WORD_W'($urandom), 1'b0);
      end
    end
    forceOutputsLow = 1'b1;
    tick(4);
    check(outputPins, OUT_RESET);
    xact(sa, CMD_BASIC_A, WORD_W'($urandom), 1'b1);
    forceOutputsLow = 1'b0;
    tick(4);
    check(outputPins, OUT_RESET);
    sawFull = 1'b0;
    for (i = 0; i < 18; i++) begin
      held = WORD_W'($urandom);
      push(sa, CMD_BASIC_B, held);
    end
    reqValid = 1'b0;
    check(sawFull, 1'b1);
    for (i = 0; i < 18; i++) begin
      expect_rsp(1'b1, inputPins);
    end
    check(outputPins, held);
    tick(2);
    srst = 1'b1;
    for (i = 0; i < 8; i++) begin
      check(outputPins, held);
      check(clockMonitorOut, 1'b1);
      #5;
      check(clockMonitorOut, 1'b0);
      tick();
    end
    srst = 1'b0;
    tick(2);
    check(outputPins, OUT_RESET);
    held = WORD_W'($urandom);
    xact(sa, CMD_BASIC_A, held, 1'b1);
    #5;
    hwRstN = 1'b0;
    #8;
    hwRstN = 1'b1;
    tick(4);
    check(outputPins, held);
    hwRstN = 1'b0;
    tick(10);
    check(outputPins, held);
    hwRstN = 1'b1;
    tick(6);
    check(outputPins, OUT_RESET);
    xact(sa, CMD_BASIC_B, WORD_W'($urandom), 1'b1);
    report_and_stop();
  end
endmodule
